// [mcpv_nvm_model.sv]
// mcpv_nvm_model: settings store seen by the supervisor's nvm port
// assumes: one boot read per power-up, writes land at once, no reset
`timescale 1ns/1ps
`default_nettype none
module mcpv_nvm_model
    import mcpv_pkg::*;
(
    input  wire logic      clock_i,
    input  wire logic      nvm_read_i,
    input  wire logic      nvm_write_i,
    input  wire mcpv_cfg_s nvm_wdata_i,
    output logic           nvm_ready_o,
    output logic           nvm_rvalid_o,
    output mcpv_cfg_s      nvm_rdata_o
);
    // factory image: servo mode, serial setpoint
    mcpv_cfg_s  store_q = '{1'b0, RESET_REPLY, PERIOD_FAST, RES_NORMAL, RESET_RAMP,
                            RESET_RAMP, WRAP_HI, 1'b0, 1'b1, 1'b0, ORIGIN_SERIAL};
    logic [1:0] dly_q   = 2'h0;
    initial begin
        nvm_ready_o  = 1'b1;
        nvm_rvalid_o = 1'b0;
        nvm_rdata_o  = '0;
    end
    always @(posedge clock_i) begin
        nvm_rvalid_o <= 1'b0;
        nvm_rdata_o  <= ~nvm_rdata_o; // released bus changes every cycle
        if (nvm_write_i) begin
            store_q <= nvm_wdata_i;
        end
        if (nvm_read_i) begin
            dly_q <= 2'h3;
        end else if (dly_q != 2'h0) begin
            dly_q <= dly_q - 2'h1;
        end
        if (dly_q == 2'h1) begin
            nvm_rvalid_o <= 1'b1;
            nvm_rdata_o  <= store_q;
        end
    end
endmodule // mcpv_nvm_model
`default_nettype wire

// [mcpv_pkg.sv]
// mcpv_pkg: constants, enums and structs for the motion command supervisor
// assumes: command decode happens upstream; this package has no logic
package mcpv_pkg;
    localparam int unsigned CLK_HZ           = 125000000;
    localparam logic [2:0]  REPLY_ASYNC      = 3'h1;
    localparam logic [2:0]  REPLY_CONFIRM    = 3'h2;
    localparam logic [7:0]  PERIOD_LEGACY    = 8'h12;
    localparam logic [7:0]  PERIOD_FAST      = 8'h01;
    localparam logic [15:0] RES_LEGACY       = 16'h03E8;
    localparam logic [15:0] RES_NORMAL       = 16'h0BB8;
    localparam logic [31:0] BOUND_DIV        = 32'h0000_0003;
    localparam logic signed [31:0] ABS_MAX   = 32'sh6B49_D200;
    localparam logic signed [31:0] ABS_MIN   = -32'sh6B49_D200;
    localparam logic signed [31:0] REL_MAX   = 32'sh7F8D_CF00;
    localparam logic signed [31:0] REL_MIN   = -32'sh7F8D_CF00;
    localparam logic signed [31:0] WRAP_HI   = 32'sh0ABA_9500;
    localparam logic signed [31:0] WRAP_LO   = -32'sh0ABA_9500;
    localparam logic [1:0]  ORIGIN_SERIAL    = 2'h0;
    localparam logic [7:0]  CHAR_POS         = 8'h70;
    localparam logic [2:0]  RESET_REPLY      = 3'h2;
    localparam logic [15:0] RESET_RAMP       = 16'h7530;

    typedef enum logic [3:0] {
        MCPV_CMD_NONE     = 4'h0,
        MCPV_CMD_LEGACY   = 4'h1,
        MCPV_CMD_REPLY    = 4'h2,
        MCPV_CMD_PERIOD   = 4'h3,
        MCPV_CMD_RAMP_UP  = 4'h4,
        MCPV_CMD_RAMP_DN  = 4'h5,
        MCPV_CMD_BOUNDS   = 4'h6,
        MCPV_CMD_ENFORCE  = 4'h7,
        MCPV_CMD_PERSIST  = 4'h8,
        MCPV_CMD_MODE     = 4'h9,
        MCPV_CMD_ABS      = 4'hA,
        MCPV_CMD_REL      = 4'hB,
        MCPV_CMD_START    = 4'hC,
        MCPV_CMD_NOTIFY   = 4'hD,
        MCPV_CMD_CANCEL   = 4'hE,
        MCPV_CMD_VELOCITY = 4'hF
    } mcpv_cmd_e;

    typedef enum logic [1:0] {
        MCPV_MODE_IDLE = 2'b00,
        MCPV_MODE_POS  = 2'b01,
        MCPV_MODE_VEL  = 2'b11
    } mcpv_mode_e;

    typedef enum logic [1:0] {
        MCPV_ST_IDLE = 2'b00,
        MCPV_ST_LOAD = 2'b01,
        MCPV_ST_RUN  = 2'b11
    } mcpv_boot_e;

    // one decoded command from the ascii parser
    typedef struct packed {
        mcpv_cmd_e          op;
        logic               has_arg;
        logic signed [31:0] arg;
    } mcpv_cmd_s;

    // settings image kept in non-volatile memory
    typedef struct packed {
        logic               legacy;
        logic [2:0]         reply_mode;
        logic [7:0]         loop_period_setting;
        logic [15:0]        resolution;
        logic [15:0]        ramp_up_rate;
        logic [15:0]        ramp_down_rate;
        logic signed [31:0] travel_bounds;
        logic               bound_enforce;
        logic               servo_sel;
        logic               servo_ext;
        logic [1:0]         setpoint_origin;
    } mcpv_cfg_s;
endpackage : mcpv_pkg

// [mcpv_top.sv]
// mcpv_top: motion command supervisor for position and velocity modes
// assumes: commands arrive decoded as one-cycle strobes on clock_i;
// actual position comes from the control loop; nvm port answers in order
// Functional notes
// - legacy on: reply 1, 1.8 ms, 1000 counts on hall variant
// - legacy off: reply 2, 0.1 ms, 3000 counts on hall variant
// - legacy ramp-up write copies to ramp-down
// - legacy divides travel bounds by three
// - explicit period write accepted after legacy change
// - persist stores settings, reloaded at power-up
// - no motion until output stage enabled
// - default servo with serial setpoint
// - position mode needs servo and origin 0
// - absolute load stores bounded target, no start
// - relative load adds to last started target
// - start enters position control toward target
// - bare notify sends p at target
// - notify with argument sends p past position
// - notifications only in reply modes 1, 2
// - cancel disarms pending notification
// - bounds writable, restrict only when enforced
// - unenforced count wraps at plus-minus 180000000
// - mid-move changes apply at next start
// - velocity mode needs servo and origin 0
// - velocity command sets signed rpm target
// - reply modes gate async and confirmations
`timescale 1ns/1ps
`default_nettype none
module mcpv_top
    import mcpv_pkg::*;
(
    input  wire logic               clock_i,
    input  wire logic               rstn_i,
    input  wire logic               cmd_valid_i,
    input  wire mcpv_cmd_s          cmd_i,
    input  wire logic               hall_variant_i,
    input  wire logic               stage_enabled_i,
    input  wire logic signed [31:0] step_i,
    input  wire logic               step_valid_i,
    input  wire logic               reply_busy_i,
    input  wire logic               tx_ready_i,
    input  wire logic               nvm_ready_i,
    input  wire logic               nvm_rvalid_i,
    input  wire mcpv_cfg_s          nvm_rdata_i,
    output logic                    nvm_read_o,
    output logic                    nvm_write_o,
    output mcpv_cfg_s               nvm_wdata_o,
    output mcpv_cfg_s               cfg_o,
    output mcpv_mode_e              mode_o,
    output logic                    motion_en_o,
    output logic signed [31:0]      target_pos_o,
    output logic signed [31:0]      actual_pos_o,
    output logic signed [31:0]      target_rpm_o,
    output logic [15:0]             run_ramp_up_o,
    output logic [15:0]             run_ramp_dn_o,
    output logic                    ack_o,
    output logic                    echo_o,
    output logic                    tx_valid_o,
    output logic [7:0]              tx_char_o
);
    // saturate a signed value into a window
    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input logic signed [31:0] lo,
                                                 input logic signed [31:0] hi);
        if (v > hi) begin
            clamp = hi;
        end else if (v < lo) begin
            clamp = lo;
        end else begin
            clamp = v;
        end
    endfunction

    function automatic logic is_cmd(input mcpv_cmd_s c, input mcpv_cmd_e op);
        is_cmd = (c.op == op);
    endfunction

    mcpv_cfg_s          cfg_q;
    mcpv_boot_e         boot_q;
    mcpv_mode_e         mode_q;
    logic signed [31:0] loaded_q;
    logic signed [31:0] started_q;
    logic signed [31:0] actual_q;
    logic signed [31:0] rpm_q;
    logic [15:0]        run_up_q;
    logic [15:0]        run_dn_q;
    logic               armed_q;
    logic               arm_arg_q;
    logic signed [31:0] arm_pos_q;
    logic               arm_above_q;
    logic               pend_q;
    logic               tx_valid_q;
    logic               ack_q;
    logic               echo_q;
    logic               nvm_rd_q;
    logic               nvm_wr_q;
    logic               persist_pend_q;
    logic               stage_s1_q;
    logic               stage_q;
    logic               motion_q;

    wire logic live = cmd_valid_i && (boot_q == MCPV_ST_RUN);
    wire logic servo_serial = (cfg_q.servo_sel || cfg_q.servo_ext)
                              && (cfg_q.setpoint_origin == ORIGIN_SERIAL);
    wire logic signed [31:0] bound_eff = cfg_q.legacy ?
                              cfg_q.travel_bounds / $signed(BOUND_DIV) : cfg_q.travel_bounds;
    wire logic signed [31:0] rel_sum = started_q + cmd_i.arg;
    wire logic reply_async = (cfg_q.reply_mode == REPLY_ASYNC)
                             || (cfg_q.reply_mode == REPLY_CONFIRM);

    // enable level arrives from the output stage pin
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage_s1_q <= 1'b0;
            stage_q    <= 1'b0;
        end else begin
            stage_s1_q <= stage_enabled_i;
            stage_q    <= stage_s1_q;
        end
    end

    // power-up reload of stored settings
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_q   <= MCPV_ST_IDLE;
            nvm_rd_q <= 1'b0;
        end else begin
            nvm_rd_q <= 1'b0;
            case (boot_q)
                MCPV_ST_IDLE: begin
                    nvm_rd_q <= 1'b1;
                    boot_q   <= MCPV_ST_LOAD;
                end
                MCPV_ST_LOAD: begin
                    if (nvm_rvalid_i) begin
                        boot_q <= MCPV_ST_RUN;
                    end
                end
                default: begin
                    boot_q <= MCPV_ST_RUN;
                end
            endcase
        end
    end

    // settings
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_q                     <= '0;
            cfg_q.reply_mode          <= RESET_REPLY;
            cfg_q.loop_period_setting <= PERIOD_FAST;
            cfg_q.resolution          <= RES_NORMAL;
            cfg_q.ramp_up_rate        <= RESET_RAMP;
            cfg_q.ramp_down_rate      <= RESET_RAMP;
            cfg_q.travel_bounds       <= WRAP_HI;
            cfg_q.servo_sel           <= 1'b1;
            cfg_q.setpoint_origin     <= ORIGIN_SERIAL;
        end else if (boot_q == MCPV_ST_LOAD && nvm_rvalid_i) begin
            cfg_q <= nvm_rdata_i;
        end else if (live) begin
            case (cmd_i.op)
                MCPV_CMD_LEGACY: begin
                    cfg_q.legacy <= cmd_i.arg[0];
                    if (cmd_i.arg[0]) begin
                        cfg_q.reply_mode          <= REPLY_ASYNC;
                        cfg_q.loop_period_setting <= PERIOD_LEGACY;
                        if (hall_variant_i) begin
                            cfg_q.resolution <= RES_LEGACY;
                        end
                    end else begin
                        cfg_q.reply_mode          <= REPLY_CONFIRM;
                        cfg_q.loop_period_setting <= PERIOD_FAST;
                        if (hall_variant_i) begin
                            cfg_q.resolution <= RES_NORMAL;
                        end
                    end
                end
                MCPV_CMD_REPLY:  cfg_q.reply_mode <= cmd_i.arg[2:0];
                MCPV_CMD_PERIOD: cfg_q.loop_period_setting <= cmd_i.arg[7:0];
                MCPV_CMD_RAMP_UP: begin
                    cfg_q.ramp_up_rate <= cmd_i.arg[15:0];
                    if (cfg_q.legacy) begin
                        cfg_q.ramp_down_rate <= cmd_i.arg[15:0];
                    end
                end
                MCPV_CMD_RAMP_DN: cfg_q.ramp_down_rate <= cmd_i.arg[15:0];
                MCPV_CMD_BOUNDS:  cfg_q.travel_bounds <= cmd_i.arg;
                MCPV_CMD_ENFORCE: cfg_q.bound_enforce <= cmd_i.arg[0];
                MCPV_CMD_MODE: begin
                    cfg_q.servo_sel       <= cmd_i.arg[0];
                    cfg_q.servo_ext       <= cmd_i.arg[1];
                    cfg_q.setpoint_origin <= cmd_i.arg[3:2];
                end
                default: begin
                end
            endcase
        end
    end

    // persist request to non-volatile memory
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            persist_pend_q <= 1'b0;
            nvm_wr_q       <= 1'b0;
        end else begin
            nvm_wr_q <= 1'b0;
            if (live && is_cmd(cmd_i, MCPV_CMD_PERSIST)) begin
                persist_pend_q <= 1'b1;
            end else if (persist_pend_q && nvm_ready_i) begin
                persist_pend_q <= 1'b0;
                nvm_wr_q       <= 1'b1;
            end
        end
    end

    // targets and motion mode
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            loaded_q  <= '0;
            started_q <= '0;
            rpm_q     <= '0;
            run_up_q  <= RESET_RAMP;
            run_dn_q  <= RESET_RAMP;
            mode_q    <= MCPV_MODE_IDLE;
        end else if (live) begin
            case (cmd_i.op)
                MCPV_CMD_ABS: loaded_q <= clamp(cmd_i.arg, ABS_MIN, ABS_MAX);
                MCPV_CMD_REL: loaded_q <= clamp(rel_sum, REL_MIN, REL_MAX);
                MCPV_CMD_START: begin
                    if (servo_serial) begin
                        mode_q    <= MCPV_MODE_POS;
                        started_q <= (cfg_q.bound_enforce) ?
                                     clamp(loaded_q, -bound_eff, bound_eff) : loaded_q;
                        run_up_q  <= cfg_q.ramp_up_rate;
                        run_dn_q  <= cfg_q.ramp_down_rate;
                    end
                end
                MCPV_CMD_VELOCITY: begin
                    if (servo_serial) begin
                        mode_q   <= MCPV_MODE_VEL;
                        rpm_q    <= cmd_i.arg;
                        run_up_q <= cfg_q.ramp_up_rate;
                        run_dn_q <= cfg_q.ramp_down_rate;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // drive gating on the output stage
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            motion_q <= 1'b0;
        end else begin
            motion_q <= stage_q && (mode_q != MCPV_MODE_IDLE);
        end
    end

    // actual position counter with wraparound
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            actual_q <= '0;
        end else if (step_valid_i && motion_q) begin
            if (!cfg_q.bound_enforce && (actual_q + step_i > WRAP_HI)) begin
                actual_q <= actual_q + step_i - WRAP_HI;
            end else if (!cfg_q.bound_enforce && (actual_q + step_i < WRAP_LO)) begin
                actual_q <= actual_q + step_i - WRAP_LO;
            end else begin
                actual_q <= actual_q + step_i;
            end
        end
    end

    // notification arming and firing
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed_q     <= 1'b0;
            arm_arg_q   <= 1'b0;
            arm_pos_q   <= '0;
            arm_above_q <= 1'b0;
            pend_q      <= 1'b0;
        end else begin
            if (pend_q && !reply_busy_i && tx_ready_i && !tx_valid_q) begin
                pend_q <= 1'b0;
            end
            if (live && is_cmd(cmd_i, MCPV_CMD_NOTIFY)) begin
                armed_q     <= 1'b1;
                arm_arg_q   <= cmd_i.has_arg;
                arm_pos_q   <= cmd_i.arg;
                arm_above_q <= cmd_i.arg > actual_q;
            end else if (live && is_cmd(cmd_i, MCPV_CMD_CANCEL)) begin
                armed_q <= 1'b0;
            end else if (armed_q && mode_q == MCPV_MODE_POS) begin
                if (!arm_arg_q && actual_q == started_q) begin
                    armed_q <= 1'b0;
                    pend_q  <= pend_q | reply_async;
                end else if (arm_arg_q && (arm_above_q ? actual_q >= arm_pos_q
                                                       : actual_q <= arm_pos_q)) begin
                    armed_q <= 1'b0;
                    pend_q  <= pend_q | reply_async;
                end
            end
        end
    end

    // transmit and reply strobes
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_valid_q <= 1'b0;
            ack_q      <= 1'b0;
            echo_q     <= 1'b0;
        end else begin
            tx_valid_q <= pend_q && !reply_busy_i && tx_ready_i && !tx_valid_q;
            ack_q      <= live && (cfg_q.reply_mode == REPLY_CONFIRM);
            echo_q     <= live && (cfg_q.reply_mode == (REPLY_CONFIRM + 3'h1));
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nvm_wdata_o <= '0;
        end else if (live && is_cmd(cmd_i, MCPV_CMD_PERSIST)) begin
            nvm_wdata_o <= cfg_q;
        end
    end

    assign nvm_read_o    = nvm_rd_q;
    assign nvm_write_o   = nvm_wr_q;
    assign cfg_o         = cfg_q;
    assign mode_o        = mode_q;
    assign motion_en_o   = motion_q;
    assign target_pos_o  = started_q;
    assign actual_pos_o  = actual_q;
    assign target_rpm_o  = rpm_q;
    assign run_ramp_up_o = run_up_q;
    assign run_ramp_dn_o = run_dn_q;
    assign ack_o         = ack_q;
    assign echo_o        = echo_q;
    assign tx_valid_o    = tx_valid_q;
    assign tx_char_o     = CHAR_POS;
endmodule // mcpv_top
`default_nettype wire

// [mcpv_top_asserts.sv]
// mcpv_top_asserts: port-level checks of the motion supervisor
// assumes: bound into mcpv_top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module mcpv_top_asserts
    import mcpv_pkg::*;
(
    input wire logic               clock_i,
    input wire logic               rstn_i,
    input wire logic               cmd_valid_i,
    input wire mcpv_cmd_s          cmd_i,
    input wire logic               hall_variant_i,
    input wire logic               stage_enabled_i,
    input wire logic               reply_busy_i,
    input wire logic               tx_ready_i,
    input wire logic               nvm_rvalid_i,
    input wire mcpv_cfg_s          nvm_wdata_o,
    input wire mcpv_cfg_s          cfg_o,
    input wire mcpv_mode_e         mode_o,
    input wire logic signed [31:0] target_pos_o,
    input wire logic signed [31:0] target_rpm_o,
    input wire logic               ack_o,
    input wire logic               motion_en_o,
    input wire logic               tx_valid_o,
    input wire logic [7:0]         tx_char_o
);
    logic boot_q;
    logic acc;
    logic srv;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_q <= 1'b0;
        end else if (nvm_rvalid_i) begin
            boot_q <= 1'b1;
        end
    end
    assign acc = boot_q & cmd_valid_i;
    assign srv = (cfg_o.servo_sel | cfg_o.servo_ext) && cfg_o.setpoint_origin == ORIGIN_SERIAL;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    legacy_on_a: assert property (acc && cmd_i.op == MCPV_CMD_LEGACY && cmd_i.arg[0] |=>
        cfg_o.reply_mode == REPLY_ASYNC && cfg_o.loop_period_setting == PERIOD_LEGACY)
        else $error("legacy on settings wrong");
    legacy_off_a: assert property (acc && cmd_i.op == MCPV_CMD_LEGACY && !cmd_i.arg[0] |=>
        cfg_o.reply_mode == REPLY_CONFIRM && cfg_o.loop_period_setting == PERIOD_FAST)
        else $error("legacy off settings wrong");
    hall_res_a: assert property (acc && cmd_i.op == MCPV_CMD_LEGACY && hall_variant_i |=>
        cfg_o.resolution == ($past(cmd_i.arg[0]) ? RES_LEGACY : RES_NORMAL))
        else $error("resolution wrong");
    ramp_copy_a: assert property (acc && cmd_i.op == MCPV_CMD_RAMP_UP && cfg_o.legacy |=>
        cfg_o.ramp_down_rate == $past(cmd_i.arg[15:0])) else $error("ramp not copied");
    abs_hold_a: assert property (acc && cmd_i.op == MCPV_CMD_ABS |=>
        $stable(mode_o) && $stable(target_pos_o)) else $error("abs load moved");
    start_pos_a: assert property (acc && cmd_i.op == MCPV_CMD_START && srv |=>
        mode_o == MCPV_MODE_POS) else $error("start not in position mode");
    vel_mode_a: assert property (acc && cmd_i.op == MCPV_CMD_VELOCITY && srv |=>
        mode_o == MCPV_MODE_VEL && target_rpm_o == $past(cmd_i.arg))
        else $error("velocity command wrong");
    stage_gate_a: assert property (!stage_enabled_i [*4] |-> !motion_en_o)
        else $error("motion without stage");
    tx_gate_a: assert property (tx_valid_o |-> !$past(reply_busy_i) && $past(tx_ready_i)
        && tx_char_o == CHAR_POS) else $error("notify char sent badly");
    persist_img_a: assert property (acc && cmd_i.op == MCPV_CMD_PERSIST |=>
        nvm_wdata_o == $past(cfg_o)) else $error("persist image wrong");
    ack_reply_a: assert property (acc && cmd_i.op inside {MCPV_CMD_ABS, MCPV_CMD_REL}
        && cfg_o.reply_mode == REPLY_CONFIRM |-> ##[1:2] ack_o) else $error("no ack");
endmodule // mcpv_top_asserts
bind mcpv_top mcpv_top_asserts u_mcpv_top_asserts (.clock_i(clock_i), .rstn_i(rstn_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .hall_variant_i(hall_variant_i),
    .stage_enabled_i(stage_enabled_i), .reply_busy_i(reply_busy_i), .tx_ready_i(tx_ready_i),
    .nvm_rvalid_i(nvm_rvalid_i), .nvm_wdata_o(nvm_wdata_o), .cfg_o(cfg_o), .mode_o(mode_o),
    .target_pos_o(target_pos_o), .target_rpm_o(target_rpm_o), .ack_o(ack_o),
    .tx_valid_o(tx_valid_o), .tx_char_o(tx_char_o), .motion_en_o(motion_en_o));
`default_nettype wire

// [tb.sv]
// tb: directed scenarios for the motion supervisor
// assumes: mcpv_top and the nvm model, 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb;
    import mcpv_pkg::*;
    logic clock_i = 1'b0, rstn_i = 1'b0, cmd_valid_i = 1'b0, hall_variant_i = 1'b0;
    logic stage_enabled_i = 1'b0, step_valid_i = 1'b0, nvm_read_o, nvm_write_o;
    logic nvm_ready_i, nvm_rvalid_i, motion_en_o, ack_o, echo_o, tx_valid_o;
    logic signed [31:0] step_i = '0, target_pos_o, actual_pos_o, target_rpm_o, pos;
    logic [15:0] run_ramp_up_o, run_ramp_dn_o;
    logic [7:0]  tx_char_o;
    mcpv_cmd_s   cmd_i = '0;
    mcpv_cfg_s   nvm_rdata_i, nvm_wdata_o, cfg_o;
    mcpv_mode_e  mode_o;
    int n_errors = 0, checks = 0;
    always #4 clock_i = ~clock_i;
    mcpv_top u_mcpv_top (.clock_i(clock_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .hall_variant_i(hall_variant_i), .stage_enabled_i(stage_enabled_i),
        .step_i(step_i), .step_valid_i(step_valid_i), .reply_busy_i(1'b0), .tx_ready_i(1'b1),
        .nvm_ready_i(nvm_ready_i), .nvm_rvalid_i(nvm_rvalid_i), .nvm_rdata_i(nvm_rdata_i),
        .nvm_read_o(nvm_read_o), .nvm_write_o(nvm_write_o), .nvm_wdata_o(nvm_wdata_o),
        .cfg_o(cfg_o), .mode_o(mode_o), .motion_en_o(motion_en_o), .target_pos_o(target_pos_o),
        .actual_pos_o(actual_pos_o), .target_rpm_o(target_rpm_o),
        .run_ramp_up_o(run_ramp_up_o), .run_ramp_dn_o(run_ramp_dn_o), .ack_o(ack_o),
        .echo_o(echo_o), .tx_valid_o(tx_valid_o), .tx_char_o(tx_char_o));
    mcpv_nvm_model u_mcpv_nvm_model (.clock_i(clock_i), .nvm_read_i(nvm_read_o),
        .nvm_write_i(nvm_write_o), .nvm_wdata_i(nvm_wdata_o), .nvm_ready_o(nvm_ready_i),
        .nvm_rvalid_o(nvm_rvalid_i), .nvm_rdata_o(nvm_rdata_i));
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // bounded wait: 0 boot answer, 1 motion enable, 2 settings write
    task automatic wt(input int k);
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clock_i);
            if ((k == 0 && nvm_rvalid_i) || (k == 1 && motion_en_o) || (k == 2 && nvm_write_o))
                break;
        end
        if (n == 40) begin
            n_errors++;
            $display("unexpected wait %0d exp 1 got 0", k);
            finish_test();
        end
    endtask
    task automatic send(input mcpv_cmd_e op, input logic signed [31:0] arg, input logic ha);
        @(posedge clock_i);
        cmd_valid_i <= 1'b1;
        cmd_i       <= '{op, ha, arg};
        @(posedge clock_i);
        cmd_valid_i <= 1'b0;
        @(posedge clock_i);
        #1;
    endtask
    task automatic step(input logic signed [31:0] v);
        repeat (2) @(posedge clock_i);
        step_valid_i <= 1'b1;
        step_i       <= v;
        @(posedge clock_i);
        step_valid_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic boot();
        rstn_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        wt(0);
    endtask
    task automatic t_boot();
        `CHK("reply", REPLY_CONFIRM, cfg_o.reply_mode)
        `CHK("servo", 1'b1, cfg_o.servo_sel)
        `CHK("origin", ORIGIN_SERIAL, cfg_o.setpoint_origin)
    endtask
    task automatic t_legacy();
        hall_variant_i <= 1'b1;
        send(MCPV_CMD_LEGACY, 32'sh0000_0001, 1'b1);
        `CHK("lreply", REPLY_ASYNC, cfg_o.reply_mode)
        `CHK("lperiod", PERIOD_LEGACY, cfg_o.loop_period_setting)
        `CHK("lres", RES_LEGACY, cfg_o.resolution)
        send(MCPV_CMD_RAMP_UP, 32'sh0000_0055, 1'b1);
        `CHK("rampdn", 16'h0055, cfg_o.ramp_down_rate)
        send(MCPV_CMD_PERIOD, 32'sh0000_0007, 1'b1);
        `CHK("uperiod", 8'h07, cfg_o.loop_period_setting)
        send(MCPV_CMD_LEGACY, 32'sh0000_0000, 1'b1);
        `CHK("nreply", REPLY_CONFIRM, cfg_o.reply_mode)
        `CHK("nperiod", PERIOD_FAST, cfg_o.loop_period_setting)
        `CHK("nres", RES_NORMAL, cfg_o.resolution)
    endtask
    task automatic t_pos();
        send(MCPV_CMD_ABS, 32'sh0000_0064, 1'b1);
        `CHK("absmode", MCPV_MODE_IDLE, mode_o)
        send(MCPV_CMD_START, 32'sh0000_0000, 1'b0);
        `CHK("postgt", 32'sh0000_0064, target_pos_o)
        `CHK("posmode", MCPV_MODE_POS, mode_o)
        send(MCPV_CMD_REL, 32'sh0000_0032, 1'b1);
        send(MCPV_CMD_START, 32'sh0000_0000, 1'b0);
        `CHK("reltgt", 32'sh0000_0096, target_pos_o)
        `CHK("runramp", 16'h0055, run_ramp_dn_o)
        `CHK("stage", 1'b0, motion_en_o)
    endtask
    task automatic t_vel();
        send(MCPV_CMD_VELOCITY, -32'sh0000_0064, 1'b1);
        `CHK("velmode", MCPV_MODE_VEL, mode_o)
        `CHK("rpm", -32'sh0000_0064, target_rpm_o)
        send(MCPV_CMD_VELOCITY, 32'sh0000_0000, 1'b1);
        `CHK("rpm0", 32'sh0000_0000, target_rpm_o)
        stage_enabled_i <= 1'b1;
        wt(1);
    endtask
    task automatic np(input logic [2:0] rep, input logic cn, input logic ha, input logic ex);
        logic seen;
        seen = 1'b0;
        send(MCPV_CMD_REPLY, {29'h0, rep}, 1'b1);
        send(MCPV_CMD_NOTIFY, pos + 10, ha);
        send(MCPV_CMD_ABS, pos + 20, 1'b1);
        send(MCPV_CMD_START, 32'sh0000_0000, 1'b0);
        if (cn) send(MCPV_CMD_CANCEL, 32'sh0000_0000, 1'b0);
        wt(1);
        fork
            step(32'sh0000_0014);
            repeat (14) @(posedge clock_i) seen |= tx_valid_o;
        join
        pos = pos + 20;
        `CHK("notify", ex, seen)
    endtask
    task automatic t_notify();
        pos = actual_pos_o;
        np(REPLY_CONFIRM, 1'b0, 1'b0, 1'b1);
        np(REPLY_ASYNC, 1'b0, 1'b1, 1'b1);
        np(REPLY_CONFIRM, 1'b1, 1'b1, 1'b0);
        np(3'h0, 1'b0, 1'b1, 1'b0);
        `CHK("actual", pos, actual_pos_o)
    endtask
    task automatic t_wrap();
        step(WRAP_HI - 32'sh0000_0014);
        `CHK("wrap", pos - 32'sh0000_0014, actual_pos_o)
    endtask
    task automatic t_persist();
        send(MCPV_CMD_REPLY, 32'sh0000_0001, 1'b1);
        send(MCPV_CMD_PERSIST, 32'sh0000_0000, 1'b0);
        wt(2);
        boot();
        repeat (2) @(posedge clock_i);
        `CHK("reload", REPLY_ASYNC, cfg_o.reply_mode)
    endtask
    initial begin
        boot();
        repeat (2) @(posedge clock_i);
        t_boot();
        t_legacy();
        t_pos();
        t_vel();
        t_notify();
        t_wrap();
        t_persist();
        finish_test();
    end
endmodule // tb
`default_nettype wire
